// file: lts_tx_status.v
// transmit status flag bank: six status flags, mask, collision count and control
// assumes engine event inputs are one-cycle pulses on sys_clk; host port on sys_clk
//
// Notes on behaviour
// [RULE1] The own-packet flag sets when our own packet comes back correctly and ignores writes.
// [RULE2] The own-packet flag clears itself whenever a new packet starts to go out.
// [RULE3] The short-packet flag sets on carrier loss mid-packet, clears at each start, ignores writes.
// [RULE4] The jabber flag sets when the watchdog stops an overlong transmission.
// [RULE5] Jabber, collision, sixteen-collision and bus-write-error clear on a written 1 only.
// [RULE6] The collision flag sets on every collision during a transmission.
// [RULE7] After a collision the packet is sent again until sixteen collisions have happened; the code retries after the sixteenth too if bits 2 and 1 are 0.
// [RULE8] The running collision count reads in bits 7 to 4 of the collision counter register.
// [RULE9] The sixteen-collision flag sets on sixteen collisions in a row for one packet.
// [RULE10] Bits 2 and 1 of the sixteen-collision control register pick what follows that error.
// [RULE11] The bus-write-error flag sets when a host write finds no room within 2.15 us.
// [RULE12] Host software treats the own-packet flag as a diagnostic only.
// [RULE13] The interrupt output rises when a set flag is enabled by its mask bit.
// [RULE14] Each write-one-to-clear flag stays set until the host clears it.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ns
`include "lts_defines.vh"

module lts_tx_status #(
  parameter                      CNT_W       = `LTS_CCNT_W,
  parameter [`LTS_RDY_CNT_W-1:0] RDY_LIMIT   = `LTS_RDY_TIMEOUT_CYC
) (
  input  wire                   sys_clk,
  input  wire                   arst_n,
  input  wire [`LTS_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  input  wire                   tx_start,
  input  wire                   own_rx_ok,
  input  wire                   carrier_lost,
  input  wire                   jabber_trip,
  input  wire                   collision,
  input  wire                   host_wr_req,
  input  wire                   tx_buf_full,
  output wire                   host_wr_ready,
  output wire                   host_wr_abort,
  output wire                   retry_req,
  output wire                   skip_pkt,
  output reg                    tx_halt,
  output reg                    int_out
);

  // flag vector, bits 5..0 of the transmit status register
  reg  [5:0]       flags_reg;
  reg  [5:0]       flags_next;
  reg  [5:0]       mask_reg;
  reg  [1:0]       scc_reg;
  reg              tx_active_reg;
  reg              halt_next;

  wire [CNT_W-1:0] coll_count;
  wire             scol_evt;
  wire             wr_err_evt;
  wire             tx_active;
  wire             wr_status;
  wire             wr_mask;
  wire             wr_scc;
  wire [5:0]       w1c;
  wire [5:0]       set_evt;

  // register read mux; unmapped offsets and bits 7..6 of the status read zero
  function [7:0] read_mux;
    input [`LTS_ADDR_W-1:0] addr;
    input [5:0]             flags;
    input [5:0]             mask;
    input [CNT_W-1:0]       count;
    input [1:0]             scc;
    begin
      case (addr)
        `LTS_OFF_TX_STATUS:    read_mux = {2'b00, flags};
        `LTS_OFF_TX_INT_MASK:  read_mux = {2'b00, mask};
        `LTS_OFF_COLL_COUNTER: read_mux = {count, 4'h0};
        `LTS_OFF_SCOL_CONTROL: read_mux = {5'b0_0000, scc, 1'b0};
        default:               read_mux = 8'h00;
      endcase
    end
  endfunction

  // one write strobe per writable register; the collision counter has none
  function wr_hit;
    input                   wr;
    input [`LTS_ADDR_W-1:0] addr;
    input [`LTS_ADDR_W-1:0] off;
    begin
      wr_hit = wr & (addr == off);
    end
  endfunction

  assign wr_status = wr_hit(reg_wr, reg_addr, `LTS_OFF_TX_STATUS);
  assign wr_mask   = wr_hit(reg_wr, reg_addr, `LTS_OFF_TX_INT_MASK);
  assign wr_scc    = wr_hit(reg_wr, reg_addr, `LTS_OFF_SCOL_CONTROL);

  // transmission window: from packet start until the packet is given up or halted
  assign tx_active = tx_active_reg | tx_start;

  // write-one-to-clear only on bits 3..0; bits 5 and 4 ignore writes [RULE1] [RULE3]
  assign w1c = wr_status ? {2'b00, reg_wdata[3:0]} : 6'h00;          // [RULE5]

  // hardware set events, one per flag
  assign set_evt[`LTS_BIT_OWN_RX]     = own_rx_ok;                    // [RULE1]
  assign set_evt[`LTS_BIT_SHORT]      = carrier_lost & tx_active;     // [RULE3]
  assign set_evt[`LTS_BIT_JABBER]     = jabber_trip;                  // [RULE4]
  assign set_evt[`LTS_BIT_COLL]       = collision & tx_active;        // [RULE6]
  assign set_evt[`LTS_BIT_SCOL]       = scol_evt;                     // [RULE9]
  assign set_evt[`LTS_BIT_BUS_WR_ERR] = wr_err_evt;                   // [RULE11]

  lts_coll_ctr #(
    .CNT_W      (CNT_W)
  ) u_coll (
    .sys_clk    (sys_clk),
    .arst_n     (arst_n),
    .tx_start   (tx_start),
    .collision  (collision & tx_active),
    .mode_skip  (scc_reg[0]),
    .mode_halt  (scc_reg[1]),
    .coll_count (coll_count),
    .retry_req  (retry_req),
    .skip_pkt   (skip_pkt),
    .scol_evt   (scol_evt)
  );

  lts_ready_timer #(
    .LIMIT         (RDY_LIMIT)
  ) u_rdy (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .host_wr_req   (host_wr_req),
    .tx_buf_full   (tx_buf_full),
    .host_wr_ready (host_wr_ready),
    .host_wr_abort (host_wr_abort),
    .timeout_evt   (wr_err_evt)
  );

  // flag update; a set event in the same cycle as a clear always wins
  always @* begin
    flags_next = flags_reg;
    // own-packet and short-packet flags drop at each packet start [RULE2] [RULE3]
    if (tx_start) begin
      flags_next[`LTS_BIT_OWN_RX] = 1'b0;
      flags_next[`LTS_BIT_SHORT]  = 1'b0;
    end
    // sticky bits fall only on a written 1 [RULE14]
    flags_next = flags_next & ~w1c;                                   // [RULE5]
    flags_next = flags_next | set_evt;
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= `LTS_RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // software-written mask and sixteen-collision control
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= `LTS_RST_MASK;
      scc_reg  <= `LTS_RST_SCC;
    end else begin
      if (wr_mask) begin
        mask_reg <= reg_wdata[5:0];
      end
      if (wr_scc) begin
        scc_reg <= {reg_wdata[`LTS_SCC_BIT_HALT], reg_wdata[`LTS_SCC_BIT_SKIP]}; // [RULE10]
      end
    end
  end

  // packet in flight: opened by start, closed when skipped or halted
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_active_reg <= 1'b0;
    end else if (tx_start) begin
      tx_active_reg <= 1'b1;
    end else if (skip_pkt || halt_next) begin
      tx_active_reg <= 1'b0;
    end
  end

  // halt after sixteen collisions holds until software clears that flag
  always @* begin
    halt_next = tx_halt;
    if (scol_evt && scc_reg[1] && !scc_reg[0]) begin
      halt_next = 1'b1;                                               // [RULE10]
    end else if (!flags_reg[`LTS_BIT_SCOL]) begin
      halt_next = 1'b0;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_halt <= 1'b0;
    end else begin
      tx_halt <= halt_next;
    end
  end

  // interrupt from any set and enabled flag
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_out <= 1'b0;
    end else begin
      int_out <= |(flags_next & mask_reg);                            // [RULE13]
    end
  end

  // read data valid only in the cycle after the read strobe
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux(reg_addr, flags_reg, mask_reg, coll_count, scc_reg); // [RULE8]
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // lts_tx_status

// file: lts_defines.vh
// constants for the transmit status flag bank: offsets, bit positions, resets, timing
// assumes inclusion by every design file of the bank; definitions only
`ifndef LTS_DEFINES_VH
`define LTS_DEFINES_VH

// register offsets on the plain register port
`define LTS_ADDR_W             4
`define LTS_OFF_TX_STATUS      4'h0
`define LTS_OFF_TX_INT_MASK    4'h2
`define LTS_OFF_COLL_COUNTER   4'h4
`define LTS_OFF_SCOL_CONTROL   4'hB

// transmit status bit positions
`define LTS_BIT_OWN_RX         5
`define LTS_BIT_SHORT          4
`define LTS_BIT_JABBER         3
`define LTS_BIT_COLL           2
`define LTS_BIT_SCOL           1
`define LTS_BIT_BUS_WR_ERR     0

// collision counter field and sixteen-collision control bits
`define LTS_CCNT_LSB           4
`define LTS_CCNT_W             4
`define LTS_SCC_BIT_SKIP       1
`define LTS_SCC_BIT_HALT       2

// reset values
`define LTS_RST_FLAGS          6'h00
`define LTS_RST_MASK           6'h00
`define LTS_RST_SCC            2'h0
`define LTS_RST_CCNT           4'h0

// host write ready timeout
`define LTS_CLK_PERIOD_NS      20
`define LTS_RDY_TIMEOUT_NS     2150
// 2150 ns at 20 ns per cycle, rounded down, sized to the timer counter
`define LTS_RDY_TIMEOUT_CYC    8'h6B
`define LTS_RDY_CNT_W          8

`endif

// file: lts_ready_timer.v
// host write ready timer: watches one pending host write of transmit data
// assumes host_wr_req is a level on sys_clk held until ready or abort
`timescale 1ns/1ns
`include "lts_defines.vh"

module lts_ready_timer #(
  parameter [`LTS_RDY_CNT_W-1:0] LIMIT = `LTS_RDY_TIMEOUT_CYC
) (
  input  wire       sys_clk,
  input  wire       arst_n,
  input  wire       host_wr_req,
  input  wire       tx_buf_full,
  output wire       host_wr_ready,
  output reg        host_wr_abort,
  output reg        timeout_evt
);

  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_ABORT = 3'b100;

  reg [2:0]                state_reg;
  reg [2:0]                state_next;
  reg [`LTS_RDY_CNT_W-1:0] cnt_reg;

  // ready only while a write is pending, room exists and it was not given up
  assign host_wr_ready = host_wr_req & ~tx_buf_full & ~state_reg[2];

  always @* begin
    case (state_reg)
      ST_IDLE:  state_next = (host_wr_req & tx_buf_full) ? ST_WAIT : ST_IDLE;
      ST_WAIT: begin
        if (!host_wr_req || !tx_buf_full)
          state_next = ST_IDLE;
        else if (cnt_reg == LIMIT - 8'h01)
          state_next = ST_ABORT;
        else
          state_next = ST_WAIT;
      end
      ST_ABORT: state_next = host_wr_req ? ST_ABORT : ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= ST_IDLE;
      cnt_reg       <= 8'h00;
      host_wr_abort <= 1'b0;
      timeout_evt   <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= (state_next == ST_WAIT) ? cnt_reg + 8'h01 : 8'h00;
      // one pulse when the wait for room has run out [RULE11]
      timeout_evt   <= state_reg[1] & (state_next == ST_ABORT);
      host_wr_abort <= state_reg[1] & (state_next == ST_ABORT);
    end
  end

endmodule // lts_ready_timer

// file: lts_coll_ctr.v
// per-packet collision counter with sixteen-collision decision
// assumes one-cycle pulses for tx_start and collision on sys_clk
`timescale 1ns/1ns
`include "lts_defines.vh"

module lts_coll_ctr #(
  parameter CNT_W = `LTS_CCNT_W
) (
  input  wire             sys_clk,
  input  wire             arst_n,
  input  wire             tx_start,
  input  wire             collision,
  input  wire             mode_skip,
  input  wire             mode_halt,
  output reg  [CNT_W-1:0] coll_count,
  output reg              retry_req,
  output reg              skip_pkt,
  output reg              scol_evt
);

  wire last_try;

  assign last_try = &coll_count;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      coll_count <= `LTS_RST_CCNT;
      retry_req  <= 1'b0;
      skip_pkt   <= 1'b0;
      scol_evt   <= 1'b0;
    end else begin
      retry_req <= 1'b0;
      skip_pkt  <= 1'b0;
      scol_evt  <= 1'b0;
      if (collision) begin
        coll_count <= coll_count + {{(CNT_W-1){1'b0}}, 1'b1}; // [RULE8]
        if (last_try) begin
          scol_evt  <= 1'b1;                                  // [RULE9]
          // behaviour after the sixteenth collision [RULE10]
          skip_pkt  <= mode_skip;
          retry_req <= ~mode_skip & ~mode_halt;
        end else begin
          retry_req <= 1'b1;                                  // [RULE7]
        end
      end else if (tx_start) begin
        coll_count <= {CNT_W{1'b0}};
      end
    end
  end

endmodule // lts_coll_ctr

// file: lts_tx_status_properties.sv
// concurrent checks on the ports of the transmit status flag bank
// assumes one sys_clk domain and arst_n asynchronous active low
`timescale 1ns/1ns
`include "lts_defines.vh"

module lts_tx_status_properties (
  input wire                   sys_clk,
  input wire                   arst_n,
  input wire [`LTS_ADDR_W-1:0] reg_addr,
  input wire [7:0]             reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [7:0]             reg_rdata,
  input wire                   tx_start,
  input wire                   own_rx_ok,
  input wire                   jabber_trip,
  input wire                   host_wr_req,
  input wire                   tx_buf_full,
  input wire                   host_wr_ready,
  input wire                   host_wr_abort
);
  wire st_rd = reg_rd && (reg_addr == `LTS_OFF_TX_STATUS);
  wire st_wr = reg_wr && (reg_addr == `LTS_OFF_TX_STATUS);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside read");
  own_set_a: assert property (own_rx_ok ##1 !tx_start ##1 st_rd |=> reg_rdata[5])
    else $error("own packet flag not set");
  own_clr_a: assert property ((tx_start && !own_rx_ok) ##1 !own_rx_ok
    ##1 st_rd |=> !reg_rdata[5])
    else $error("own packet flag not cleared at start");
  jab_set_a: assert property (jabber_trip ##1 !(st_wr && reg_wdata[3]) ##1 st_rd
    |=> reg_rdata[3])
    else $error("jabber flag not set");
  jab_w1c_a: assert property ((st_wr && reg_wdata[3] && !jabber_trip) ##1 !jabber_trip
    ##1 st_rd |=> !reg_rdata[3])
    else $error("jabber flag not cleared by write");
  flag_sticky_a: assert property (st_rd ##1 !reg_wr ##1 st_rd
    |=> (($past(reg_rdata, 2) & 8'h0f) & ~reg_rdata) == 8'h00)
    else $error("sticky flag dropped without clear");
  abort_flag_a: assert property (host_wr_abort ##1 st_rd |=> reg_rdata[0])
    else $error("bus write error flag not set");
  abort_cause_a: assert property (host_wr_abort
    |-> ($past(tx_buf_full) && $past(host_wr_req)) ##1 !host_wr_abort)
    else $error("abort without full buffer or too long");
  ready_gate_a: assert property (host_wr_ready
    |-> host_wr_req && !tx_buf_full && !host_wr_abort)
    else $error("ready while buffer full");
endmodule // lts_tx_status_properties

bind lts_tx_status lts_tx_status_properties i_lts_tx_status_properties (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_start(tx_start),
  .own_rx_ok(own_rx_ok), .jabber_trip(jabber_trip), .host_wr_req(host_wr_req),
  .tx_buf_full(tx_buf_full), .host_wr_ready(host_wr_ready), .host_wr_abort(host_wr_abort));

// file: lts_host_writer.sv
// host side model writing transmit data: raises a request, holds it to ready or abort
// assumes go is a one-cycle pulse from the bench on sys_clk
`timescale 1ns/1ns

module lts_host_writer (
  input  wire sys_clk,
  input  wire arst_n,
  input  wire go,
  input  wire host_wr_ready,
  input  wire host_wr_abort,
  output reg  host_wr_req
);
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      host_wr_req <= 1'b0;
    else if (host_wr_req && (host_wr_ready || host_wr_abort))
      host_wr_req <= 1'b0;
    else if (go)
      host_wr_req <= 1'b1;
  end
endmodule // lts_host_writer

// file: lts_tx_status_test.sv
// self-checking bench for the transmit status flag bank with random mask values
// assumes the design files and the checker bind are compiled beforehand
`timescale 1ns/1ns
`include "lts_defines.vh"

module lts_tx_status_test;
  localparam LIM = 8;
  reg        sys_clk, arst_n, reg_wr, reg_rd, tx_buf_full, go;
  reg  [3:0] reg_addr;
  reg  [7:0] reg_wdata, r;
  reg  [4:0] ev;
  wire [7:0] reg_rdata;
  wire       host_wr_req, host_wr_ready, host_wr_abort, retry_req, skip_pkt, tx_halt, int_out;
  integer    seed, err_total, n_checks, n_retry, n_skip, k, m, i;

  lts_tx_status #(.RDY_LIMIT(LIM)) i_lts_tx_status (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_start(ev[4]), .own_rx_ok(ev[3]), .carrier_lost(ev[2]),
    .jabber_trip(ev[1]), .collision(ev[0]), .host_wr_req(host_wr_req),
    .tx_buf_full(tx_buf_full), .host_wr_ready(host_wr_ready), .host_wr_abort(host_wr_abort),
    .retry_req(retry_req), .skip_pkt(skip_pkt), .tx_halt(tx_halt), .int_out(int_out));
  lts_host_writer i_lts_host_writer (.sys_clk(sys_clk), .arst_n(arst_n), .go(go),
    .host_wr_ready(host_wr_ready), .host_wr_abort(host_wr_abort), .host_wr_req(host_wr_req));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (retry_req === 1'b1) n_retry = n_retry + 1;
    if (skip_pkt === 1'b1) n_skip = n_skip + 1;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
      err_total = err_total + 1;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] exp, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  task pulse(input [4:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 5'h00;
  endtask
  task wt(input bit abrt);
    for (k = 0; k < 50; k = k + 1) begin
      #1;
      if ((abrt ? host_wr_abort : host_wr_ready) === 1'b1) break;
      @(posedge sys_clk);
    end
    if (k == 50) begin
      err_total = err_total + 1;
      complete_run;
    end
  endtask

  initial begin
    #1_000_000 err_total = err_total + 1;
    complete_run;
  end
  initial begin
    seed = 28898; err_total = 0; n_checks = 0; n_retry = 0; n_skip = 0;
    arst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
    ev = 5'h00; tx_buf_full = 1'b0; go = 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(4'h0, 8'h00, "status"); rd(4'h2, 8'h00, "mask");
    rd(4'h4, 8'h00, "count"); rd(4'hB, 8'h00, "control");
    repeat (4) begin
      r = $random(seed);
      wr(4'h2, r); rd(4'h2, r & 8'h3f, "mask");
      wr(4'h7, r); rd(4'h7, 8'h00, "unmapped");
    end
    $display("test reset and mask done");
    pulse(5'h10); pulse(5'h08); rd(4'h0, 8'h20, "own set");
    wr(4'h0, 8'hff); rd(4'h0, 8'h20, "own write");
    pulse(5'h10); rd(4'h0, 8'h00, "own start");
    pulse(5'h10); pulse(5'h04); rd(4'h0, 8'h10, "short set");
    wr(4'h0, 8'h10); rd(4'h0, 8'h10, "short write");
    pulse(5'h10); rd(4'h0, 8'h00, "short start");
    $display("test own and short done");
    wr(4'h2, 8'h08); pulse(5'h02); rd(4'h0, 8'h08, "jabber set");
    chk("int on", {7'h00, int_out}, 8'h01);
    rd(4'h0, 8'h08, "jabber held");
    wr(4'h0, 8'h37); rd(4'h0, 8'h08, "jabber zero write");
    wr(4'h0, 8'h08); rd(4'h0, 8'h00, "jabber clear");
    chk("int off", {7'h00, int_out}, 8'h00);
    $display("test jabber done");
    for (m = 0; m < 3; m = m + 1) begin
      wr(4'hB, (m == 0) ? 8'h00 : ((m == 1) ? 8'h02 : 8'h04));
      pulse(5'h10);
      n_retry = 0; n_skip = 0;
      for (i = 1; i <= 16; i = i + 1) begin
        pulse(5'h01);
        if (i == 5) rd(4'h4, 8'h50, "count five");
      end
      repeat (2) @(posedge sys_clk);
      rd(4'h0, 8'h06, "collision flags");
      chk("retries", n_retry[7:0], (m == 0) ? 8'h10 : 8'h0f);
      chk("skips", n_skip[7:0], (m == 1) ? 8'h01 : 8'h00);
      chk("halt", {7'h00, tx_halt}, (m == 2) ? 8'h01 : 8'h00);
      wr(4'h0, 8'h06); rd(4'h0, 8'h00, "collision clear");
      chk("halt clear", {7'h00, tx_halt}, 8'h00);
    end
    $display("test collisions done");
    @(posedge sys_clk);
    tx_buf_full <= 1'b1; go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wt(1'b1);
    chk("abort delay", {7'h00, (k >= LIM - 2) && (k <= LIM + 2)}, 8'h01);
    rd(4'h0, 8'h01, "bus write error");
    @(posedge sys_clk);
    tx_buf_full <= 1'b0; go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wt(1'b0);
    rd(4'h0, 8'h01, "bus error held");
    wr(4'h0, 8'h01); rd(4'h0, 8'h00, "bus error clear");
    $display("test bus write done");
    complete_run;
  end
endmodule // lts_tx_status_test
